// ### logic/umc_pkg.sv
// constants, types and codes for the usb microcontroller core
// assumes one 10 mhz system clock; core steps are qualified by a tick
package umc_pkg;
    localparam int unsigned PC_W = 15;
    localparam int unsigned SP_W = 10;
    localparam logic signed [17:0] PROG_WORDS = 18'sh06000;
    // data space map
    localparam logic [15:0] IO_BASE   = 16'h0020;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] A_SPL     = 16'h005D;
    localparam logic [15:0] A_SPH     = 16'h005E;
    localparam logic [15:0] A_SREG    = 16'h005F;
    // status bits
    localparam int unsigned SR_I = 2;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_C = 0;
    // reset values
    localparam logic [SP_W-1:0] SP_RST = 10'h000;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [2:0]      SR_RST = 3'h0;
    // module clock rates in khz
    localparam logic [15:0] F_24M = 16'h5DC0;
    localparam logic [15:0] F_12M = 16'h2EE0;
    localparam logic [15:0] F_1M5 = 16'h05DC;
    localparam logic [15:0] F_1M  = 16'h03E8;
    // opcodes, bits 15:12 of an instruction word
    localparam logic [3:0] OP_NOP  = 4'h0;
    localparam logic [3:0] OP_ALU  = 4'h1;
    localparam logic [3:0] OP_LDI  = 4'h2;
    localparam logic [3:0] OP_SUBI = 4'h3;
    localparam logic [3:0] OP_ANDI = 4'h4;
    localparam logic [3:0] OP_ORI  = 4'h5;
    localparam logic [3:0] OP_SGL  = 4'h6;
    localparam logic [3:0] OP_LDST = 4'h7;
    localparam logic [3:0] OP_IO   = 4'h8;
    localparam logic [3:0] OP_LPM  = 4'h9;
    localparam logic [3:0] OP_JMP  = 4'hA;
    localparam logic [3:0] OP_CALL = 4'hB;
    localparam logic [3:0] OP_RET  = 4'hC;
    localparam logic [3:0] OP_SEI  = 4'hD;

    typedef enum logic [5:0] {
        S_EXEC = 6'h01,
        S_PUSH = 6'h02,
        S_POPH = 6'h04,
        S_POPL = 6'h08,
        S_LOAD = 6'h10,
        S_LPM  = 6'h20
    } umc_state_t;

    typedef struct packed {
        logic [15:0] core;
        logic [15:0] timer;
        logic [15:0] adc;
        logic [15:0] spi;
        logic [15:0] wdt;
    } umc_clk_plan_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } umc_dbus_t;
endpackage

// ### logic/umc_core.sv
// eight-bit risc core with module clock plan
// assumes external program memory answering prog_addr_out in the same
// cycle, and data/io slaves that hold read data until the next tick
// Behaviour
// - full speed: core and spi 24 mhz (select 0) or 12 mhz, timer 12 mhz, adc and watchdog 1 mhz.
// - low speed: core and spi 24 mhz with 12 mhz timer, or all three 1.5 mhz with select 1.
// - the core advances only on ticks handed over by the usb hardware, which may jitter.
// - 32 byte registers; two are read, combined and one written in one step.
// - the alu works register with register, constant with register, and on one register.
// - four register pairs act as 16-bit pointers (the fourth wraps to r1:r0); r31:r30 also serves program table reads.
// - data addresses 0x00 to 0x1F reach the working registers.
// - 64 io addresses are reached by io instructions and as data addresses 0x20 to 0x5F.
// - the next word is fetched while the current instruction executes.
// - long jumps and calls reach all 24k words; instructions are one or two words.
// - calls and interrupts push the return address into sram via a 10-bit stack pointer in io.
// - interrupts need the global enable bit and each has its own vector at the bottom.
// - of several pending interrupts the lowest vector goes first.
`timescale 1ns/1ps
module umc_core #(
    parameter int unsigned N_IRQ = 8
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  usb_full_speed_in,
    input  wire logic                  clock_rate_select_in,
    input  wire logic                  core_tick_in,
    input  wire logic [15:0]           prog_data_in,
    input  wire logic [7:0]            data_rdata_in,
    input  wire logic [N_IRQ-1:0]      irq_req_in,
    output logic [14:0]                prog_addr_out,
    output umc_pkg::umc_dbus_t         dbus_out,
    output umc_pkg::umc_clk_plan_t     clk_plan_out,
    output logic [N_IRQ-1:0]           irq_ack_out
);
    if (N_IRQ < 1 || N_IRQ > 31) begin : g_chk
        $error("N_IRQ must lie in 1..31");
    end

    logic [7:0]             rf_r [32];
    logic [14:0]            pc_r, pc_nxt, ret_r, ret_nxt, push_ret;
    logic [15:0]            ir_r, ir_nxt;
    logic                   irv_r, irv_nxt, take, push_go, rf_we;
    logic [9:0]             sp_r, sp_nxt;
    logic [2:0]             sreg_r, sreg_nxt;
    logic [7:0]             tmp_r, tmp_nxt, rf_wd, alu_a, alu_b, alu_y;
    logic [7:0]             io_rd;
    logic [4:0]             rf_wa, rd5, acc_rd;
    logic                   alu_c, acc_st;
    logic [15:0]            ptr, acc_addr, zptr;
    logic [3:0]             op;
    umc_pkg::umc_state_t    st_r, st_nxt;
    umc_pkg::umc_dbus_t     db_r, db_nxt;
    umc_pkg::umc_clk_plan_t plan_r, plan_nxt;
    logic [N_IRQ-1:0]       ack_r, ack_nxt;

    function automatic logic [14:0] pc_wrap(input logic signed [17:0] t);
        logic signed [17:0] v;
        v = t;
        for (int i = 0; i < 2; i++) begin
            if (v < 0) v = v + umc_pkg::PROG_WORDS;
            if (v >= umc_pkg::PROG_WORDS) v = v - umc_pkg::PROG_WORDS;
        end
        return v[14:0];
    endfunction

    function automatic logic [N_IRQ-1:0] first_irq(input logic [N_IRQ-1:0] r);
        return r & (~r + 1'b1);
    endfunction

    function automatic logic [14:0] vec_of(input logic [N_IRQ-1:0] r);
        logic [14:0] v;
        v = '0;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (r[i]) v = 15'(i + 1);
        end
        return v;
    endfunction

    assign prog_addr_out = pc_r;
    assign dbus_out      = db_r;
    assign clk_plan_out  = plan_r;
    assign irq_ack_out   = ack_r;

    // module clock plan
    always_comb begin
        plan_nxt.adc = umc_pkg::F_1M;
        plan_nxt.wdt = umc_pkg::F_1M;
        if (!clock_rate_select_in) begin
            plan_nxt.core  = umc_pkg::F_24M;
            plan_nxt.timer = umc_pkg::F_12M;
        end else if (usb_full_speed_in) begin
            plan_nxt.core  = umc_pkg::F_12M;
            plan_nxt.timer = umc_pkg::F_12M;
        end else begin
            plan_nxt.core  = umc_pkg::F_1M5;
            plan_nxt.timer = umc_pkg::F_1M5;
        end
        plan_nxt.spi = plan_nxt.core;
    end

    // operand decode and alu
    assign op     = ir_r[15:12];
    assign rd5    = ir_r[9:5];
    assign ptr    = {rf_r[5'(27 + 2 * ir_r[9:8])],
                     rf_r[5'(26 + 2 * ir_r[9:8])]};
    assign zptr   = {rf_r[31], rf_r[30]};
    assign acc_addr = (op == umc_pkg::OP_LDST) ? ptr
                    : umc_pkg::IO_BASE + {10'h000, ir_r[5:0]};
    assign acc_st = (op == umc_pkg::OP_LDST) ? ir_r[10] : ir_r[11];
    assign acc_rd = (op == umc_pkg::OP_LDST) ? ir_r[4:0] : ir_r[10:6];
    assign take   = core_tick_in && st_r == umc_pkg::S_EXEC && irv_r
                    && sreg_r[umc_pkg::SR_I] && |irq_req_in;

    always_comb begin
        io_rd = {sreg_r[2], 5'h00, sreg_r[1:0]};
        if (acc_addr == umc_pkg::A_SPL) io_rd = sp_r[7:0];
        if (acc_addr == umc_pkg::A_SPH) io_rd = {6'h00, sp_r[9:8]};
    end

    always_comb begin
        alu_a = (op == umc_pkg::OP_ALU || op == umc_pkg::OP_SGL)
              ? rf_r[rd5] : rf_r[{1'b1, ir_r[11:8]}];
        alu_b = (op == umc_pkg::OP_ALU) ? rf_r[ir_r[4:0]] : ir_r[7:0];
        {alu_c, alu_y} = {1'b0, alu_b};
        unique case (op)
            umc_pkg::OP_SGL: begin
                unique case (ir_r[11:10])
                    2'h0: {alu_c, alu_y} = {1'b0, alu_a} + 9'h001;
                    2'h1: {alu_c, alu_y} = {1'b0, alu_a} - 9'h001;
                    2'h2: {alu_c, alu_y} = {1'b1, ~alu_a};
                    2'h3: {alu_c, alu_y} = {alu_a[0], 1'b0, alu_a[7:1]};
                endcase
            end
            umc_pkg::OP_ALU, umc_pkg::OP_SUBI, umc_pkg::OP_ANDI,
            umc_pkg::OP_ORI: begin
                unique case (op == umc_pkg::OP_ALU ? ir_r[11:10]
                             : 2'(op - umc_pkg::OP_LDI))
                    2'h0: {alu_c, alu_y} = {1'b0, alu_a} + {1'b0, alu_b};
                    2'h1: {alu_c, alu_y} = {1'b0, alu_a} - {1'b0, alu_b};
                    2'h2: {alu_c, alu_y} = {1'b0, alu_a & alu_b};
                    2'h3: {alu_c, alu_y} = {1'b0, alu_a | alu_b};
                endcase
            end
            default: ;
        endcase
    end

    // sequencer
    always_comb begin
        pc_nxt = pc_r;      ir_nxt = ir_r;     irv_nxt = irv_r;
        sp_nxt = sp_r;      sreg_nxt = sreg_r; st_nxt = st_r;
        tmp_nxt = tmp_r;    ret_nxt = ret_r;   ack_nxt = '0;
        db_nxt = '0;
        db_nxt.addr = db_r.addr;
        rf_we = 1'b0;       rf_wa = rd5;       rf_wd = alu_y;
        push_go = 1'b0;     push_ret = pc_r;
        if (core_tick_in) begin
            unique case (st_r)
            umc_pkg::S_EXEC: begin
                pc_nxt  = pc_wrap($signed({3'h0, pc_r}) + 18'sh00001);
                ir_nxt  = prog_data_in;
                irv_nxt = 1'b1;
                if (take) begin
                    push_go  = 1'b1;
                    push_ret = pc_wrap($signed({3'h0, pc_r}) - 18'sh00001);
                    pc_nxt   = vec_of(irq_req_in);
                    ack_nxt  = first_irq(irq_req_in);
                    sreg_nxt[umc_pkg::SR_I] = 1'b0;
                end else if (irv_r) begin
                    unique case (op)
                    umc_pkg::OP_ALU, umc_pkg::OP_LDI, umc_pkg::OP_SUBI,
                    umc_pkg::OP_ANDI, umc_pkg::OP_ORI, umc_pkg::OP_SGL: begin
                        rf_we = 1'b1;
                        if (op != umc_pkg::OP_ALU && op != umc_pkg::OP_SGL)
                            rf_wa = {1'b1, ir_r[11:8]};
                        if (op != umc_pkg::OP_LDI)
                            sreg_nxt[1:0] = {alu_y == 8'h00, alu_c};
                    end
                    umc_pkg::OP_LDST, umc_pkg::OP_IO: begin
                        if (acc_addr < umc_pkg::IO_BASE) begin
                            rf_we = 1'b1;
                            rf_wa = acc_st ? acc_addr[4:0] : acc_rd;
                            rf_wd = acc_st ? rf_r[acc_rd]
                                           : rf_r[acc_addr[4:0]];
                        end else if (acc_addr >= umc_pkg::A_SPL
                                     && acc_addr <= umc_pkg::A_SREG) begin
                            rf_we = !acc_st;
                            rf_wa = acc_rd;
                            rf_wd = io_rd;
                            if (acc_st) begin
                                if (acc_addr == umc_pkg::A_SPL)
                                    sp_nxt[7:0] = rf_r[acc_rd];
                                else if (acc_addr == umc_pkg::A_SPH)
                                    sp_nxt[9:8] = rf_r[acc_rd][1:0];
                                else
                                    sreg_nxt = {rf_r[acc_rd][7],
                                                rf_r[acc_rd][1:0]};
                            end
                        end else begin
                            db_nxt.we    = acc_st;
                            db_nxt.re    = !acc_st;
                            db_nxt.addr  = acc_addr;
                            db_nxt.wdata = rf_r[acc_rd];
                            tmp_nxt = {3'h0, acc_rd};
                            if (!acc_st) st_nxt = umc_pkg::S_LOAD;
                        end
                    end
                    umc_pkg::OP_LPM: begin
                        pc_nxt  = zptr[15:1];
                        ret_nxt = pc_r;
                        irv_nxt = 1'b0;
                        tmp_nxt = {zptr[0], 2'h0, ir_r[4:0]};
                        st_nxt  = umc_pkg::S_LPM;
                    end
                    umc_pkg::OP_JMP, umc_pkg::OP_CALL: begin
                        pc_nxt  = pc_wrap($signed({3'h0, pc_r}) + 18'sh00001
                                  + $signed({{2{prog_data_in[15]}},
                                             prog_data_in}));
                        irv_nxt = 1'b0;
                        push_go = (op == umc_pkg::OP_CALL);
                        push_ret = pc_wrap($signed({3'h0, pc_r})
                                           + 18'sh00001);
                    end
                    umc_pkg::OP_RET: begin
                        sp_nxt      = sp_r + 10'h001;
                        db_nxt.re   = 1'b1;
                        db_nxt.addr = {6'h00, sp_r + 10'h001};
                        irv_nxt     = 1'b0;
                        st_nxt      = umc_pkg::S_POPH;
                        if (ir_r[0]) sreg_nxt[umc_pkg::SR_I] = 1'b1;
                    end
                    umc_pkg::OP_SEI: sreg_nxt[umc_pkg::SR_I] = ir_r[0];
                    default: ;
                    endcase
                end
                if (push_go) begin
                    db_nxt.we    = 1'b1;
                    db_nxt.addr  = {6'h00, sp_r};
                    db_nxt.wdata = push_ret[7:0];
                    sp_nxt  = sp_r - 10'h001;
                    tmp_nxt = {1'b0, push_ret[14:8]};
                    irv_nxt = 1'b0;
                    st_nxt  = umc_pkg::S_PUSH;
                end
            end
            umc_pkg::S_PUSH: begin
                db_nxt.we    = 1'b1;
                db_nxt.addr  = {6'h00, sp_r};
                db_nxt.wdata = tmp_r;
                sp_nxt = sp_r - 10'h001;
                st_nxt = umc_pkg::S_EXEC;
            end
            umc_pkg::S_POPH: begin
                tmp_nxt     = data_rdata_in;
                sp_nxt      = sp_r + 10'h001;
                db_nxt.re   = 1'b1;
                db_nxt.addr = {6'h00, sp_r + 10'h001};
                st_nxt      = umc_pkg::S_POPL;
            end
            umc_pkg::S_POPL: begin
                pc_nxt = {tmp_r[6:0], data_rdata_in};
                st_nxt = umc_pkg::S_EXEC;
            end
            umc_pkg::S_LOAD: begin
                rf_we = 1'b1;
                rf_wa = tmp_r[4:0];
                rf_wd = data_rdata_in;
                st_nxt = umc_pkg::S_EXEC;
            end
            umc_pkg::S_LPM: begin
                rf_we = 1'b1;
                rf_wa = tmp_r[4:0];
                rf_wd = tmp_r[7] ? prog_data_in[15:8] : prog_data_in[7:0];
                pc_nxt = ret_r;
                st_nxt = umc_pkg::S_EXEC;
            end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pc_r <= umc_pkg::PC_RST;  ir_r <= '0;   irv_r <= 1'b0;
            sp_r <= umc_pkg::SP_RST;  sreg_r <= umc_pkg::SR_RST;
            st_r <= umc_pkg::S_EXEC;  tmp_r <= '0;  ret_r <= '0;
            db_r <= '0;  plan_r <= '0;  ack_r <= '0;
        end else begin
            pc_r <= pc_nxt;  ir_r <= ir_nxt;  irv_r <= irv_nxt;
            sp_r <= sp_nxt;  sreg_r <= sreg_nxt;  st_r <= st_nxt;
            tmp_r <= tmp_nxt;  ret_r <= ret_nxt;
            db_r <= db_nxt;  plan_r <= plan_nxt;  ack_r <= ack_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rf_we) rf_r[rf_wa] <= rf_wd;
    end

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_take;
        take;
    endsequence
    sequence s_push_done;
        st_r == umc_pkg::S_PUSH && sp_r == $past(sp_r) - 10'h001;
    endsequence

    a_plan_full: assert property (usb_full_speed_in && clock_rate_select_in
        |=> clk_plan_out.core == umc_pkg::F_12M
            && clk_plan_out.timer == umc_pkg::F_12M)
        else $error("full speed plan wrong");
    a_plan_low: assert property (!usb_full_speed_in && clock_rate_select_in
        |=> clk_plan_out.spi == umc_pkg::F_1M5
            && clk_plan_out.timer == umc_pkg::F_1M5)
        else $error("low speed plan wrong");
    a_plan_fixed: assert property ($past(rst_b_in)
        |-> clk_plan_out.adc == umc_pkg::F_1M && clk_plan_out.wdt == umc_pkg::F_1M)
        else $error("adc or watchdog rate wrong");
    a_tick_stall: assert property (!core_tick_in
        |=> $stable(pc_r) && $stable(st_r))
        else $error("core moved without tick");
    a_fetch_ahead: assert property (core_tick_in && st_r == umc_pkg::S_EXEC
        && op == umc_pkg::OP_NOP && !take
        |=> irv_r && ir_r == $past(prog_data_in))
        else $error("prefetch lost");
    a_alu_add: assert property (core_tick_in && irv_r && !take
        && st_r == umc_pkg::S_EXEC && op == umc_pkg::OP_ALU
        && ir_r[11:10] == 2'h0 && rd5 != ir_r[4:0]
        |=> rf_r[$past(rd5)] == 8'($past(rf_r[rd5]) + $past(rf_r[ir_r[4:0]])))
        else $error("register add wrong");
    a_irq_gate: assert property (!sreg_r[umc_pkg::SR_I]
        |=> irq_ack_out == '0)
        else $error("interrupt taken while disabled");
    a_irq_prio: assert property (s_take
        |=> irq_ack_out == first_irq($past(irq_req_in))
            && pc_r == vec_of($past(irq_req_in)))
        else $error("wrong interrupt served");
    a_irq_push: assert property (s_take |=> s_push_done)
        else $error("return address not pushed");
    a_ext_route: assert property (dbus_out.we || dbus_out.re
        |-> dbus_out.addr >= umc_pkg::IO_BASE
            && (dbus_out.addr >= umc_pkg::SRAM_BASE
                || dbus_out.addr < umc_pkg::A_SPL))
        else $error("bus access to internal location");
endmodule

// ### testbench/umc_mem_model.sv
// behavioural program memory, data sram and io registers for the core
// assumes the bench loads rom and sram contents before ticking the core
`timescale 1ns/1ps
module umc_mem_model (
    input  wire logic               clk_sys_in,
    input  wire logic [14:0]        prog_addr_in,
    input  wire umc_pkg::umc_dbus_t dbus_in,
    output logic [15:0]             prog_data_out,
    output logic [7:0]              data_rdata_out
);
    logic [15:0] rom  [0:24575];
    logic [7:0]  sram [0:1023];
    logic [7:0]  held_r;

    initial begin
        for (int i = 0; i < 24576; i++) begin
            rom[i] = 16'h0000;
        end
        for (int i = 0; i < 1024; i++) begin
            sram[i] = 8'h00;
        end
        held_r = 8'h00;
    end

    // words past the end of rom read back a fixed pattern made from the inverted address
    assign prog_data_out = (prog_addr_in < 15'h6000) ?
                           rom[prog_addr_in] : {1'b1, ~prog_addr_in};

    // io and sram share one array; read data answers in the strobe cycle,
    // so a tick on the very next edge sees it, then holds until next read
    assign data_rdata_out = dbus_in.re ? sram[dbus_in.addr[9:0]] : held_r;

    always @(posedge clk_sys_in) begin
        if (dbus_in.we) begin
            sram[dbus_in.addr[9:0]] <= dbus_in.wdata;
        end
        if (dbus_in.re) begin
            held_r <= sram[dbus_in.addr[9:0]];
        end
    end
endmodule

// ### testbench/umc_core_tb.sv
// self-checking bench for the core: clock plan, instruction run, interrupt
// assumes umc_mem_model stands in for program memory, sram and io
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end

module umc_core_tb;
    logic                   clk_sys_in;
    logic                   rst_b_in;
    logic                   usb_full_speed_in;
    logic                   clock_rate_select_in;
    logic                   core_tick_in;
    logic [7:0]             irq_req_in;
    logic [15:0]            prog_data;
    logic [7:0]             data_rdata;
    logic [14:0]            prog_addr_out;
    umc_pkg::umc_dbus_t     dbus_out;
    umc_pkg::umc_clk_plan_t clk_plan_out;
    logic [7:0]             irq_ack_out;
    int                     failures;
    int                     n_checks;
    int                     cyc;
    int                     n_acks;
    bit                     run_en;

    umc_core #(.N_IRQ(8)) dut_u (
        .clk_sys_in           (clk_sys_in),
        .rst_b_in             (rst_b_in),
        .usb_full_speed_in    (usb_full_speed_in),
        .clock_rate_select_in (clock_rate_select_in),
        .core_tick_in         (core_tick_in),
        .prog_data_in         (prog_data),
        .data_rdata_in        (data_rdata),
        .irq_req_in           (irq_req_in),
        .prog_addr_out        (prog_addr_out),
        .dbus_out             (dbus_out),
        .clk_plan_out         (clk_plan_out),
        .irq_ack_out          (irq_ack_out)
    );

    umc_mem_model mem_u (
        .clk_sys_in     (clk_sys_in),
        .prog_addr_in   (prog_addr_out),
        .dbus_in        (dbus_out),
        .prog_data_out  (prog_data),
        .data_rdata_out (data_rdata)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk_sys_in);
        #5;
        cyc++;
        if (irq_ack_out !== 8'h00) begin
            n_acks++;
            `CHK(irq_ack_out, 8'h04)
            `CHK(prog_addr_out, 15'h0003)
            irq_req_in = 8'h00;
        end
        // uneven tick spacing stands in for usb clock jitter
        core_tick_in = run_en && (cyc % 4 != 3);
    endtask

    task automatic wait_pc(input logic [14:0] pc);
        int k;
        k = 0;
        while (prog_addr_out !== pc && k < 3000) begin
            step();
            k++;
        end
        if (k == 3000) begin
            failures++;
            $display("unexpected at %0t: core stalled", $time);
            tally_and_finish();
        end
    endtask

    task automatic check_clock_plan();
        logic [15:0] core_e;
        logic [15:0] tmr_e;
        for (int m = 0; m < 4; m++) begin
            usb_full_speed_in = m[1];
            clock_rate_select_in = m[0];
            step();
            step();
            core_e = !m[0] ? umc_pkg::F_24M :
                     (m[1] ? umc_pkg::F_12M : umc_pkg::F_1M5);
            tmr_e = !m[0] ? umc_pkg::F_12M : core_e;
            `CHK(clk_plan_out.core, core_e)
            `CHK(clk_plan_out.spi, core_e)
            `CHK(clk_plan_out.timer, tmr_e)
            `CHK(clk_plan_out.adc, umc_pkg::F_1M)
            `CHK(clk_plan_out.wdt, umc_pkg::F_1M)
        end
    endtask

    task automatic run_program();
        // stack pointer loaded first, then alu, pointers, io, lpm, call
        logic [15:0] prog [0:47] = '{
            16'h20FF, 16'h8C3D, 16'h2100, 16'h8C7E, 16'h245C, 16'h250F,
            16'h1295, 16'h8D00, 16'h1695, 16'h8D01, 16'h1A95, 16'h8D02,
            16'h1E95, 16'h8D03, 16'h6280, 16'h8D04, 16'h6680, 16'h8D05,
            16'h6A80, 16'h8D06, 16'h6E80, 16'h8D07, 16'h3408, 16'h8D08,
            16'h4430, 16'h8D09, 16'h5405, 16'h8D0A, 16'h2A03, 16'h2B00,
            16'h7414, 16'h88CB, 16'h2C80, 16'h2D00, 16'h7514, 16'h2C90,
            16'h7112, 16'h8C8C, 16'h2EFE, 16'h2F00, 16'h9013, 16'h8CCD,
            16'h8590, 16'h8D8E, 16'hB000, 16'hA013, 16'h0000, 16'hD001};
        // address in the upper byte, value written there in the lower
        logic [15:0] exp_mem [0:15] = '{
            16'h206B, 16'h215C, 16'h220C, 16'h230F, 16'h2410, 16'h250F,
            16'h26F0, 16'h2778, 16'h2870, 16'h2930, 16'h2A35, 16'h2B35,
            16'h2CC3, 16'h2DA5, 16'h2E3C, 16'h8035};
        for (int i = 0; i < 48; i++) begin
            mem_u.rom[32 + i] = prog[i];
        end
        mem_u.rom[0] = 16'hA000;
        mem_u.rom[1] = 16'h001E;
        mem_u.rom[3] = 16'hC001;
        mem_u.rom[16'h62] = 16'hC000;
        mem_u.rom[16'h7F] = 16'h5AA5;
        mem_u.sram[16'h90] = 8'hC3;
        mem_u.sram[16'h30] = 8'h3C;
        irq_req_in = 8'h24;
        run_en = 1'b1;
        wait_pc(15'h0050);
        `CHK(n_acks, 0)
        `CHK(mem_u.sram[16'hFF], 8'h4E)
        `CHK(mem_u.sram[16'hFE], 8'h00)
        wait_pc(15'h005A);
        run_en = 1'b0;
        repeat (4) step();
        `CHK(n_acks, 1)
        `CHK(mem_u.sram[16'hFF] inside {[8'h50:8'h58]}, 1'b1)
        `CHK(mem_u.sram[16'hFE], 8'h00)
        `CHK(mem_u.sram[3], 8'h00)
        for (int i = 0; i < 16; i++) begin
            `CHK(mem_u.sram[exp_mem[i][15:8]], exp_mem[i][7:0])
        end
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        rst_b_in = 1'b0;
        usb_full_speed_in = 1'b1;
        clock_rate_select_in = 1'b0;
        core_tick_in = 1'b0;
        irq_req_in = 8'h00;
        failures = 0;
        n_checks = 0;
        cyc = 0;
        n_acks = 0;
        run_en = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #5;
        rst_b_in = 1'b1;
        check_clock_plan();
        run_program();
        tally_and_finish();
    end
endmodule
